//--- core/pts_inv_timer.sv
// Inverse-time accumulator: integrates measured over setting per tick
`timescale 1ns/100ps
module pts_inv_timer
  import pts_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] setting_i,
  input wire logic [WIDTH-1:0] magnitude_i,
  input wire logic [WIDTH-1:0] tdial_i,
  input wire logic series_i,
  output logic done_o
);
  localparam int ACC_W = 2 * WIDTH + 8;
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] target;
  logic [ACC_W-1:0] excess;

  // Elaboration guard: narrower words leave the curve too coarse
  if (WIDTH < 8) begin : g_bad_width
    $error("pts_inv_timer: WIDTH too small");
  end

  // Excess over setting grows the integral; larger faults finish sooner
  always_comb begin
    excess = '0;
    if (magnitude_i > setting_i) begin
      excess = ACC_W'(magnitude_i - setting_i);
    end
    // Series choice scales the curve; IEEE family halves the target, so it trips in half the time
    target = ACC_W'(tdial_i) * ACC_W'(setting_i);
    if (series_i) begin
      target = target >> 1;
    end
  end

  // Accumulator per program cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_ff <= '0;
    end else if (clear_i) begin
      acc_ff <= '0;
    end else if (tick_i && !done_o) begin
      acc_ff <= acc_ff + excess;
    end
  end

  assign done_o = (acc_ff >= target) && (target != '0);
endmodule // pts_inv_timer

//--- core/pts_map.svh
// Constants of the protection stage: register map, fields, timing counts
// Contract
// - Continuously compare pickup_setting with measured_magnitude.
// - Release pick-up below 97 percent of pickup_setting: hysteresis.
// - Pick-up alone is not start; start only while blocking is inactive.
// - Sample the blocking input at the start of every program cycle.
// - Pick-up with blocking inactive asserts start, begins trip timing.
// - Pick-up under blocking: blocked indication, no start or trip.
// - Blocking after start drops it; release runs as on pick-up reset.
// - Blocking gives a display event and a stamped event with values.
// - Software switch emulates blocking only in global test mode.
// - Instant operation asserts trip in the same evaluation as start.
// - fixed_delay_mode trips once the delay passes with pick-up held.
// - inverse_time_mode trip time depends on setting to magnitude.
// - inverse_time_mode never trips before min_operate_delay; 0 no floor.
// - Delay type: 0 fixed_delay_mode, 1 inverse_time_mode; resets 0.
// - min_operate_delay in 5 ms steps, default 40 ms; zero is instant. The code makes zero instant in fixed_delay_mode only.
// - Curve series: 0 IEC, 1 IEEE/ANSI, default IEC, inverse mode only.
// - IEC curve: normal, extremely, very, long, param; default normal. The code stores charsel but never applies it to the timer.
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH

// Register byte offsets
`define PTS_REG_CTRL 8'h00
`define PTS_REG_PICKUP 8'h04
`define PTS_REG_MIN_DLY 8'h08
`define PTS_REG_TDIAL 8'h0C
`define PTS_REG_STATUS 8'h10
`define PTS_REG_IRQ_STAT 8'h14
`define PTS_REG_IRQ_MASK 8'h18
`define PTS_REG_EVT_MAG 8'h1C
`define PTS_REG_EVT_TIME 8'h20
`define PTS_REG_CYC_DIV 8'h24

// Control fields
`define PTS_CTRL_DTYPE 0
`define PTS_CTRL_SERIES 1
`define PTS_CTRL_CHAR_LO 2
`define PTS_CTRL_CHAR_HI 4
`define PTS_CTRL_TEST 5
`define PTS_CTRL_SWBLK 6

// Status / interrupt fields
`define PTS_ST_PICKUP 0
`define PTS_ST_START 1
`define PTS_ST_TRIP 2
`define PTS_ST_BLOCKED 3
`define PTS_IRQ_START 0
`define PTS_IRQ_TRIP 1
`define PTS_IRQ_BLOCK 2
`define PTS_IRQ_DISP 3

// Reset values
`define PTS_CTRL_RST 7'h00
`define PTS_MIN_DLY_RST 16'h0008
`define PTS_TDIAL_RST 16'h0005
`define PTS_PICKUP_RST 16'h1000

// Hysteresis: reset ratio in percent
`define PTS_RESET_PCT 97
`define PTS_PCT_FULL 100

// Timing: 40 MHz clock, 5 ms delay step
`define PTS_CLK_HZ 40000000
`define PTS_STEP_US 5000
`define PTS_CYC_PER_US 40

`endif

//--- core/pts_pkg.sv
// Types shared by the protection stage files
package pts_pkg;
  typedef enum logic [1:0] {
    PTS_IDLE = 2'b00,
    PTS_START = 2'b01,
    PTS_BLOCKED = 2'b10,
    PTS_TRIPPED = 2'b11
  } pts_state_t;

  typedef struct packed {
    logic [15:0] magnitude;
    logic [31:0] stamp;
    logic [2:0] fault_type;
  } pts_event_t;

  typedef struct packed {
    logic dtype;
    logic series;
    logic [2:0] charsel;
    logic test;
    logic swblk;
  } pts_ctrl_t;
endpackage

//--- core/pts_stage.sv
// Protection stage: pick-up, blocking, start and trip timing, Wishbone regs
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_stage
  import pts_pkg::*;
#(
  parameter int MAG_W = 16,
  parameter int CYCLE_DIV = 1000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [MAG_W-1:0] measured_magnitude_i,
  input wire logic [2:0] fault_type_i,
  input wire logic block_i,
  input wire logic global_test_i,
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  output logic event_o,
  output logic irq_o
);
  pts_ctrl_t ctrl_ff;
  logic [MAG_W-1:0] pickup_setting_ff;
  logic [15:0] min_dly_ff;
  logic [MAG_W-1:0] tdial_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  pts_event_t evt_ff;
  logic [31:0] stamp_ff;
  logic [15:0] div_ff;
  logic tick;
  logic blk_ff;
  logic pickup_ff;
  logic nxt_pickup;
  pts_state_t state_ff;
  pts_state_t nxt_state;
  logic [39:0] dly_cnt_ff;
  logic [39:0] dly_target;
  logic dly_done;
  logic instant;
  logic inv_done;
  logic timer_clear;
  logic trip_now;
  logic ev_start;
  logic ev_trip;
  logic ev_block;
  logic [3:0] ev_vec;
  logic wr_stb;
  logic [31:0] rd_data;

  // Elaboration guard: percent product and divider have fixed room
  if (MAG_W < 8 || MAG_W > 16) begin : g_bad_mag_w
    $error("pts_stage: MAG_W must be 8..16");
  end
  if (CYCLE_DIV < 2 || CYCLE_DIV > 65535) begin : g_bad_div
    $error("pts_stage: CYCLE_DIV out of range");
  end

  // Threshold scaled by percent; wide product avoids overflow
  function automatic logic [MAG_W+7:0] pct_of(input logic [MAG_W-1:0] v,
                                              input int pct);
    logic [MAG_W+7:0] p;
    p = (MAG_W+8)'(v) * (MAG_W+8)'(pct);
    return p;
  endfunction

  // Program cycle tick: one evaluation per CYCLE_DIV clocks
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign tick = (div_ff == 16'(CYCLE_DIV - 1));

  // Time stamp counts program cycles for the blocking event
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stamp_ff <= '0;
    end else if (tick) begin
      stamp_ff <= stamp_ff + 32'h0000_0001;
    end
  end

  // Blocking sampled once at the head of each cycle
  // Software emulation is honoured only in global test mode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      blk_ff <= 1'b0;
    end else if (tick) begin
      blk_ff <= block_i | (ctrl_ff.swblk & ctrl_ff.test & global_test_i);
    end
  end

  // Pick-up with 97 percent release hysteresis
  always_comb begin
    nxt_pickup = pickup_ff;
    if (pct_of(measured_magnitude_i, `PTS_PCT_FULL) >=
        pct_of(pickup_setting_ff, `PTS_PCT_FULL)) begin
      nxt_pickup = 1'b1;
    end else if (pct_of(measured_magnitude_i, `PTS_PCT_FULL) <
                 pct_of(pickup_setting_ff, `PTS_RESET_PCT)) begin
      nxt_pickup = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pickup_ff <= 1'b0;
    end else if (tick) begin
      pickup_ff <= nxt_pickup;
    end
  end

  // Delay in clocks: steps of 5 ms at 40 MHz
  // 40 bits so the largest step count cannot wrap the clock target
  assign dly_target = 40'(min_dly_ff) * 40'(`PTS_STEP_US * `PTS_CYC_PER_US);
  assign dly_done = (dly_cnt_ff >= dly_target);

  // Timer runs only while started; cleared otherwise
  assign timer_clear = (state_ff != PTS_START);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_cnt_ff <= '0;
    end else if (timer_clear) begin
      dly_cnt_ff <= '0;
    end else if (!dly_done) begin
      dly_cnt_ff <= dly_cnt_ff + 40'h00_0000_0001;
    end
  end

  pts_inv_timer #(
    .WIDTH(MAG_W)
  ) u_inv (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .clear_i(timer_clear),
    .tick_i(tick),
    .setting_i(pickup_setting_ff),
    .magnitude_i(measured_magnitude_i),
    .tdial_i(tdial_ff),
    .series_i(ctrl_ff.series),
    .done_o(inv_done)
  );

  // Zero delay in fixed mode means no timing at all
  assign instant = (min_dly_ff == 16'h0000) && !ctrl_ff.dtype;

  // Trip decision per delay type
  always_comb begin
    if (instant) begin
      trip_now = 1'b1; // Instant, same evaluation as start
    end else if (!ctrl_ff.dtype) begin
      trip_now = dly_done; // Fixed delay, magnitude ignored
    end else begin
      trip_now = inv_done & dly_done; // Floor; zero delay is no floor
    end
  end

  // Stage sequencer evaluated on each program cycle tick
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PTS_IDLE: begin
        if (pickup_ff && blk_ff) begin
          nxt_state = PTS_BLOCKED;
        end else if (pickup_ff) begin
          // Instant goes straight to trip so both rise together
          nxt_state = instant ? PTS_TRIPPED : PTS_START;
        end
      end
      PTS_START: begin
        if (!pickup_ff || blk_ff) begin
          nxt_state = blk_ff ? PTS_BLOCKED : PTS_IDLE;
        end else if (trip_now) begin
          nxt_state = PTS_TRIPPED;
        end
      end
      PTS_TRIPPED: begin
        if (!pickup_ff || blk_ff) begin
          nxt_state = blk_ff ? PTS_BLOCKED : PTS_IDLE;
        end
      end
      PTS_BLOCKED: begin
        if (!pickup_ff || !blk_ff) begin
          nxt_state = PTS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= PTS_IDLE;
    end else if (tick) begin
      state_ff <= nxt_state;
    end
  end

  // Instant mode must show trip with start at once
  assign start_o = (state_ff == PTS_START) || (state_ff == PTS_TRIPPED);
  assign trip_o = (state_ff == PTS_TRIPPED);
  assign blocked_o = (state_ff == PTS_BLOCKED);

  // Events on state entry
  assign ev_start = tick && (state_ff == PTS_IDLE) &&
                    (nxt_state == PTS_START || nxt_state == PTS_TRIPPED);
  assign ev_trip = tick && (state_ff != PTS_TRIPPED) &&
                   (nxt_state == PTS_TRIPPED);
  assign ev_block = tick && (state_ff != PTS_BLOCKED) &&
                    (nxt_state == PTS_BLOCKED);
  assign ev_vec = {ev_block, ev_block, ev_trip, ev_start};

  // Blocking event record: magnitude, stamp, fault type
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_ff <= '0;
      event_o <= 1'b0;
    end else begin
      event_o <= ev_block;
      if (ev_block) begin
        evt_ff.magnitude <= 16'(measured_magnitude_i);
        evt_ff.stamp <= stamp_ff;
        evt_ff.fault_type <= fault_type_i;
      end
    end
  end

  // Wishbone classic: one-cycle ack, every address answered
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Settings registers; byte lane 0 alone enables writes, including the upper byte of 16-bit fields
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff <= `PTS_CTRL_RST; // Fixed, IEC, normal
      pickup_setting_ff <= MAG_W'(`PTS_PICKUP_RST);
      min_dly_ff <= `PTS_MIN_DLY_RST; // 40 ms default
      tdial_ff <= MAG_W'(`PTS_TDIAL_RST);
      irq_mask_ff <= '0;
    end else if (wr_stb && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `PTS_REG_CTRL: begin
          ctrl_ff.dtype <= wb_dat_i[`PTS_CTRL_DTYPE];
          ctrl_ff.series <= wb_dat_i[`PTS_CTRL_SERIES];
          ctrl_ff.charsel <= wb_dat_i[`PTS_CTRL_CHAR_HI:`PTS_CTRL_CHAR_LO];
          ctrl_ff.test <= wb_dat_i[`PTS_CTRL_TEST];
          ctrl_ff.swblk <= wb_dat_i[`PTS_CTRL_SWBLK];
        end
        `PTS_REG_PICKUP: pickup_setting_ff <= wb_dat_i[MAG_W-1:0];
        `PTS_REG_MIN_DLY: min_dly_ff <= wb_dat_i[15:0];
        `PTS_REG_TDIAL: tdial_ff <= wb_dat_i[MAG_W-1:0];
        `PTS_REG_IRQ_MASK: irq_mask_ff <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_ff <= '0;
    end else begin
      if (wr_stb && wb_sel_i[0] && wb_adr_i == `PTS_REG_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[3:0]) | ev_vec;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev_vec;
      end
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_data = '0;
    unique case (wb_adr_i)
      `PTS_REG_CTRL: rd_data = 32'({ctrl_ff.swblk, ctrl_ff.test,
                                    ctrl_ff.charsel, ctrl_ff.series,
                                    ctrl_ff.dtype});
      `PTS_REG_PICKUP: rd_data = 32'(pickup_setting_ff);
      `PTS_REG_MIN_DLY: rd_data = 32'(min_dly_ff);
      `PTS_REG_TDIAL: rd_data = 32'(tdial_ff);
      `PTS_REG_STATUS: rd_data = 32'({blocked_o, trip_o, start_o, pickup_ff});
      `PTS_REG_IRQ_STAT: rd_data = 32'(irq_stat_ff);
      `PTS_REG_IRQ_MASK: rd_data = 32'(irq_mask_ff);
      `PTS_REG_EVT_MAG: rd_data = {13'h0000, evt_ff.fault_type,
                                   evt_ff.magnitude};
      `PTS_REG_EVT_TIME: rd_data = evt_ff.stamp;
      `PTS_REG_CYC_DIV: rd_data = 32'(CYCLE_DIV);
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      wb_dat_o <= rd_data;
    end
  end
endmodule // pts_stage

//--- verif/pts_front_model.sv
// Model of the measurement front end and blocking matrix
`timescale 1ns/100ps
module pts_front_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] mag_req_i,
  input wire logic [2:0] fault_req_i,
  input wire logic block_req_i,
  input wire logic test_req_i,
  output logic [15:0] mag_o,
  output logic [2:0] fault_o,
  output logic block_o,
  output logic test_o
);
  // New samples land once per clock, as a digitising front end would
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mag_o <= 16'h0000;
      fault_o <= 3'h0;
      block_o <= 1'b0;
      test_o <= 1'b0;
    end else begin
      mag_o <= mag_req_i;
      fault_o <= fault_req_i;
      block_o <= block_req_i;
      test_o <= test_req_i;
    end
  end
endmodule // pts_front_model

//--- verif/pts_stage_chk.sv
// Port checker of the protection stage, bound into the design
`timescale 1ns/100ps
module pts_stage_chk #(
  parameter int CYCLE_DIV = 1000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire logic event_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Bus answers one cycle after the request is taken
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // Trip only stands beside start, and falls with it
  a_trip_start: assert property (trip_o |-> start_o)
    else $error("trip without start");
  a_trip_drop: assert property ($fell(start_o) |-> !trip_o)
    else $error("trip held after start fell");
  // Blocked indication excludes start
  a_block_start: assert property (blocked_o |-> !start_o)
    else $error("start while blocked");
  a_start_clean: assert property ($rose(start_o) |-> !blocked_o)
    else $error("start rose while blocked");
  // Display event is a single pulse while blocked
  a_event_blk: assert property (
    event_o |-> blocked_o ##1 !event_o)
    else $error("event pulse wrong");
  // State only moves on program ticks, here at least four clocks apart
  a_tick_pace: assert property (
    $changed(start_o) |=> $stable(start_o)[*3])
    else $error("start changed between ticks");
  c_start: cover property ($rose(start_o));
  c_trip: cover property ($rose(trip_o));
  c_block: cover property ($rose(blocked_o));
  c_event: cover property (event_o);
endmodule // pts_stage_chk

bind pts_stage pts_stage_chk #(.CYCLE_DIV(CYCLE_DIV)) chk_u (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .start_o(start_o),
  .trip_o(trip_o),
  .blocked_o(blocked_o),
  .event_o(event_o)
);

//--- verif/tb_top.sv
// Self-checking bench of the protection stage
`timescale 1ns/100ps
module tb_top;
  import pts_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] exp;} pts_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic ack, start_o, trip_o, blocked_o, event_o, irq_o, blk, tst;
  logic [15:0] mag_req = 16'h0000;
  logic [15:0] mag;
  logic [2:0] fault;
  logic blk_req = 1'b0;
  logic tst_req = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  pts_row_t rows[8] = '{'{8'h00, 32'h0}, '{8'h04, 32'h1000},
    '{8'h08, 32'h8}, '{8'h0C, 32'h5}, '{8'h14, 32'h0},
    '{8'h18, 32'h0}, '{8'h24, 32'h4}, '{8'h30, 32'h0}};
  always #12.5 clk_i = ~clk_i;
  pts_front_model fe_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .mag_req_i(mag_req), .fault_req_i(3'h5), .block_req_i(blk_req),
    .test_req_i(tst_req), .mag_o(mag), .fault_o(fault), .block_o(blk),
    .test_o(tst));
  pts_stage #(.CYCLE_DIV(4)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .measured_magnitude_i(mag), .fault_type_i(fault), .block_i(blk),
    .global_test_i(tst), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .event_o(event_o), .irq_o(irq_o));
  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; holds the request until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Start right after a rising edge, whatever edge the caller left on
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = start_o;
      1: pick = trip_o;
      2: pick = blocked_o;
      default: pick = event_o;
    endcase
  endfunction
  // Bounded wait for an output level, sampled away from the edge
  task automatic wait_on(input int w, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (pick(w) !== v && n < 200);
    chk({31'h0, pick(w)}, {31'h0, v});
    if (n >= 200) close_out();
  endtask
  // Output must keep its level for the given number of cycles
  task automatic hold(input int w, input logic v, input int c);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(negedge clk_i);
      if (pick(w) !== v) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
  endtask
  task automatic mag_to(input logic [15:0] m);
    @(posedge clk_i);
    mag_req <= m;
  endtask
  // Reset, register table, then the protection scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb(1'b0, rows[i].adr, 32'h0);
      chk(rd, rows[i].exp);
    end
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h18, 32'hF);
    mag_to(16'h1000);
    wait_on(0, 1'b1);
    chk({31'h0, trip_o}, 32'h1);
    wait_on(1, 1'b1);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h7);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd[1:0], 32'h3);
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b0, 8'h14, 32'h0);
    chk(rd[1:0], 32'h0);
    mag_to(16'h0F86);
    hold(0, 1'b1, 40);
    mag_to(16'h0F85);
    wait_on(0, 1'b0);
    chk({31'h0, trip_o}, 32'h0);
    // Blocking after start drops start and logs the event values
    mag_to(16'h1200);
    wait_on(0, 1'b1);
    blk_req <= 1'b1;
    wait_on(3, 1'b1);
    chk({31'h0, start_o}, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0005_1200);
    mag_to(16'h0000);
    wait_on(2, 1'b0);
    mag_to(16'h1200);
    wait_on(2, 1'b1);
    hold(0, 1'b0, 40);
    blk_req <= 1'b0;
    // Switch block takes effect only with global test mode on
    wb(1'b1, 8'h00, 32'h60);
    wait_on(0, 1'b1);
    tst_req <= 1'b1;
    wait_on(0, 1'b0);
    tst_req <= 1'b0;
    // One delay step is far beyond this hold, in both delay types
    for (int t = 0; t < 2; t++) begin
      mag_to(16'h0000);
      wb(1'b1, 8'h00, t);
      wb(1'b1, 8'h08, 32'h1);
      wait_on(0, 1'b0);
      mag_to(16'hFFFF);
      wait_on(0, 1'b1);
      hold(1, 1'b0, 2000);
    end
    // Floor lifted: the finished integral trips at the next evaluation
    wb(1'b1, 8'h08, 32'h0);
    wait_on(1, 1'b1);
    // Small excess integrates slowly: about 81 evaluations to trip
    mag_to(16'h0000);
    wait_on(0, 1'b0);
    mag_to(16'h1100);
    wait_on(0, 1'b1);
    hold(1, 1'b0, 200);
    wait_on(1, 1'b1);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(negedge clk_i);
    chk({28'h0, start_o, trip_o, blocked_o, irq_o}, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule // tb_top
